/* logic/lfr_pkg.sv */
/*
  Package for the LED fault status and clear register bank: register
  offsets, field positions, command values and reset values.
  Assumes a 10-bit register address and 8-bit data from the serial
  control front end.
*/
package lfr_pkg;

  localparam int unsigned ADDR_W   = 10;
  localparam int unsigned DATA_W   = 8;
  localparam int unsigned NUM_CH   = 18;

  // Register offsets
  localparam logic [9:0] OFS_GLOBAL_FAULT = 10'h064;
  localparam logic [9:0] OFS_OPEN_LOW     = 10'h065;
  localparam logic [9:0] OFS_OPEN_MID     = 10'h066;
  localparam logic [9:0] OFS_OPEN_TOP     = 10'h067;
  localparam logic [9:0] OFS_SHORT_LOW    = 10'h086;
  localparam logic [9:0] OFS_SHORT_MID    = 10'h087;
  localparam logic [9:0] OFS_SHORT_TOP    = 10'h088;
  localparam logic [9:0] OFS_OPEN_CLEAR   = 10'h0a7;
  localparam logic [9:0] OFS_SHORT_CLEAR  = 10'h0a8;
  localparam logic [9:0] OFS_SOFT_RESET   = 10'h0a9;

  // Field positions
  localparam int unsigned GLOBAL_OPEN_BIT  = 1;
  localparam int unsigned GLOBAL_SHORT_BIT = 0;
  localparam int unsigned CLEAR_LSB        = 0;
  localparam int unsigned CLEAR_MSB        = 3;
  localparam int unsigned LOW_BASE         = 0;
  localparam int unsigned MID_BASE         = 8;
  localparam int unsigned TOP_BASE         = 16;
  localparam int unsigned TOP_WIDTH        = 2;

  // Command values and reset values
  localparam logic [3:0] CLEAR_CMD        = 4'hf;
  localparam logic [7:0] SOFT_RESET_CMD   = 8'hff;
  localparam logic [7:0] READ_ZERO        = 8'h00;
  localparam logic [17:0] FLAGS_RESET     = 18'h00000;

  // One register access from the control front end
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [9:0]        addr;
    logic [7:0]        wdata;
  } lfr_req_t;

  // Fault events from the detectors
  typedef struct packed {
    logic [17:0]       open_set;
    logic [17:0]       short_set;
  } lfr_evt_t;

endpackage

/* logic/lfr_fault_regs.sv */
/*
  LED fault status and clear register bank for 18 current-sink channels.
  Sticky open and short flags, global summary, write-to-clear commands
  and a software reset command.
  Assumes the serial front end and the fault detectors run on CLK_I and
  present one-cycle strobes; register access is the device's own port.
*/
`timescale 1ns/1ns
module lfr_fault_regs #(
  parameter int unsigned NUM_CH = lfr_pkg::NUM_CH
) (
  // Clock and reset
  input  wire logic                     CLK_I,
  input  wire logic                     RST_I,
  // Register access
  input  wire logic                     REG_WR_I,
  input  wire logic                     REG_RD_I,
  input  wire logic [9:0]               REG_ADDR_I,
  input  wire logic [7:0]               REG_WDATA_I,
  output logic      [7:0]               REG_RDATA_O,
  output logic                          REG_RVALID_O,
  // Fault detector events, one cycle per detection
  input  wire logic [NUM_CH-1:0]        OPEN_SET_I,
  input  wire logic [NUM_CH-1:0]        SHORT_SET_I,
  // Status and device reset
  output logic [NUM_CH-1:0]             OPEN_FLAGS_O,
  output logic [NUM_CH-1:0]             SHORT_FLAGS_O,
  output logic                          SOFT_RESET_O
);

  lfr_pkg::lfr_req_t req;
  lfr_pkg::lfr_evt_t evt;

  logic [NUM_CH-1:0] open_flag;
  logic [NUM_CH-1:0] short_flag;
  logic [NUM_CH-1:0] next_open_flag;
  logic [NUM_CH-1:0] next_short_flag;
  logic              soft_rst;
  logic              next_soft_rst;
  logic [7:0]        rdata;
  logic [7:0]        next_rdata;
  logic              rvalid;
  logic              next_rvalid;
  logic              open_clr;
  logic              short_clr;
  logic              soft_cmd;
  logic [3:0]        clr_code;

  assign req = '{wr: REG_WR_I, rd: REG_RD_I, addr: REG_ADDR_I, wdata: REG_WDATA_I};
  assign evt = '{open_set: OPEN_SET_I, short_set: SHORT_SET_I};

  // Write decode; a write anywhere else is dropped
  function automatic logic wr_hit(input lfr_pkg::lfr_req_t r, input logic [9:0] ofs);
    wr_hit = r.wr && (r.addr == ofs);
  endfunction

  // Eight-bit slice of a flag vector, zero above the vector end
  function automatic logic [7:0] slice8(input logic [NUM_CH-1:0] v, input int unsigned base);
    logic [7:0] s;
    s = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (base + i < NUM_CH) begin
        s[i] = v[base + i];
      end
    end
    slice8 = s;
  endfunction

  // For the two clears only the low nibble is the command, upper bits don't-care; soft reset compares all eight bits
  assign clr_code  = req.wdata[lfr_pkg::CLEAR_MSB:lfr_pkg::CLEAR_LSB];
  assign open_clr  = wr_hit(req, lfr_pkg::OFS_OPEN_CLEAR) &&
                     (clr_code == lfr_pkg::CLEAR_CMD);
  assign short_clr = wr_hit(req, lfr_pkg::OFS_SHORT_CLEAR) &&
                     (clr_code == lfr_pkg::CLEAR_CMD);
  assign soft_cmd  = wr_hit(req, lfr_pkg::OFS_SOFT_RESET) &&
                     (req.wdata == lfr_pkg::SOFT_RESET_CMD);

  // Sticky flags; a detection in the clear cycle survives the clear
  always_comb begin
    next_open_flag  = open_flag;
    next_short_flag = short_flag;
    if (soft_rst) begin
      next_open_flag  = lfr_pkg::FLAGS_RESET[NUM_CH-1:0];
      next_short_flag = lfr_pkg::FLAGS_RESET[NUM_CH-1:0];
    end else begin
      if (open_clr) begin
        next_open_flag = '0;
      end
      if (short_clr) begin
        next_short_flag = '0;
      end
      next_open_flag  = next_open_flag | evt.open_set;
      next_short_flag = next_short_flag | evt.short_set;
    end
  end

  // One-cycle device reset pulse, registered so it never loops back combinationally
  always_comb begin
    next_soft_rst = soft_cmd && !soft_rst;
  end

  // Read mux; reserved bits, write-only and unmapped offsets read zero
  always_comb begin
    next_rvalid = req.rd;
    next_rdata  = lfr_pkg::READ_ZERO;
    if (req.rd) begin
      unique case (req.addr)
        lfr_pkg::OFS_GLOBAL_FAULT: begin
          next_rdata[lfr_pkg::GLOBAL_OPEN_BIT]  = |open_flag;
          next_rdata[lfr_pkg::GLOBAL_SHORT_BIT] = |short_flag;
        end
        lfr_pkg::OFS_OPEN_LOW:    next_rdata = slice8(open_flag, lfr_pkg::LOW_BASE);
        lfr_pkg::OFS_OPEN_MID:    next_rdata = slice8(open_flag, lfr_pkg::MID_BASE);
        lfr_pkg::OFS_OPEN_TOP:    next_rdata = slice8(open_flag, lfr_pkg::TOP_BASE);
        lfr_pkg::OFS_SHORT_LOW:   next_rdata = slice8(short_flag, lfr_pkg::LOW_BASE);
        lfr_pkg::OFS_SHORT_MID:   next_rdata = slice8(short_flag, lfr_pkg::MID_BASE);
        lfr_pkg::OFS_SHORT_TOP:   next_rdata = slice8(short_flag, lfr_pkg::TOP_BASE);
        default:                  next_rdata = lfr_pkg::READ_ZERO;
      endcase
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      open_flag  <= '0;
      short_flag <= '0;
      soft_rst   <= 1'b0;
      rdata      <= 8'h00;
      rvalid     <= 1'b0;
    end else begin
      open_flag  <= next_open_flag;
      short_flag <= next_short_flag;
      soft_rst   <= next_soft_rst;
      rdata      <= next_rdata;
      rvalid     <= next_rvalid;
    end
  end

  assign REG_RDATA_O   = rdata;
  assign REG_RVALID_O  = rvalid;
  assign OPEN_FLAGS_O  = open_flag;
  assign SHORT_FLAGS_O = short_flag;
  assign SOFT_RESET_O  = soft_rst;

  // Checks
  property p_open_clear;
    @(posedge CLK_I) disable iff (RST_I)
      (open_clr && !soft_rst) |=> (open_flag == $past(evt.open_set));
  endproperty
  a_open_clear: assert property (p_open_clear) else $error("open clear failed");

  property p_short_clear;
    @(posedge CLK_I) disable iff (RST_I)
      (short_clr && !soft_rst) |=> (short_flag == $past(evt.short_set));
  endproperty
  a_short_clear: assert property (p_short_clear) else $error("short clear failed");

  property p_soft_reset;
    @(posedge CLK_I) disable iff (RST_I)
      (soft_cmd && !soft_rst) |=> soft_rst ##1
        (open_flag == '0 && short_flag == '0);
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset failed");

  property p_open_sticky;
    @(posedge CLK_I) disable iff (RST_I)
      (!open_clr && !soft_rst) |=> ((open_flag & $past(open_flag)) == $past(open_flag));
  endproperty
  a_open_sticky: assert property (p_open_sticky) else $error("open flag lost");

  property p_short_set;
    @(posedge CLK_I) disable iff (RST_I)
      (|evt.short_set && !soft_rst) |=>
        ((short_flag & $past(evt.short_set)) == $past(evt.short_set));
  endproperty
  a_short_set: assert property (p_short_set) else $error("short event lost");

  property p_global;
    @(posedge CLK_I) disable iff (RST_I)
      (req.rd && req.addr == lfr_pkg::OFS_GLOBAL_FAULT) |=>
        (rvalid && rdata == {6'h00, |$past(open_flag), |$past(short_flag)});
  endproperty
  a_global: assert property (p_global) else $error("global summary wrong");

  property p_open_mid;
    @(posedge CLK_I) disable iff (RST_I)
      (req.rd && req.addr == lfr_pkg::OFS_OPEN_MID) |=> (rdata == $past(open_flag[15:8]));
  endproperty
  a_open_mid: assert property (p_open_mid) else $error("open mid read wrong");

  property p_open_top;
    @(posedge CLK_I) disable iff (RST_I)
      (req.rd && req.addr == lfr_pkg::OFS_OPEN_TOP) |=>
        (rdata == {6'h00, $past(open_flag[17:16])});
  endproperty
  a_open_top: assert property (p_open_top) else $error("open top read wrong");

  property p_short_low;
    @(posedge CLK_I) disable iff (RST_I)
      (req.rd && req.addr == lfr_pkg::OFS_SHORT_LOW) |=> (rdata == $past(short_flag[7:0]));
  endproperty
  a_short_low: assert property (p_short_low) else $error("short low read wrong");

  property p_short_mid;
    @(posedge CLK_I) disable iff (RST_I)
      (req.rd && req.addr == lfr_pkg::OFS_SHORT_MID) |=> (rdata == $past(short_flag[15:8]));
  endproperty
  a_short_mid: assert property (p_short_mid) else $error("short mid read wrong");

  property p_short_top;
    @(posedge CLK_I) disable iff (RST_I)
      (req.rd && req.addr == lfr_pkg::OFS_SHORT_TOP) |=>
        (rdata == {6'h00, $past(short_flag[17:16])});
  endproperty
  a_short_top: assert property (p_short_top) else $error("short top read wrong");

  property p_open_low;
    @(posedge CLK_I) disable iff (RST_I)
      (req.rd && req.addr == lfr_pkg::OFS_OPEN_LOW) |=> (rdata == $past(open_flag[7:0]));
  endproperty
  a_open_low: assert property (p_open_low) else $error("open low read wrong");

  property p_open_set;
    @(posedge CLK_I) disable iff (RST_I)
      (|evt.open_set && !soft_rst) |=>
        ((open_flag & $past(evt.open_set)) == $past(evt.open_set));
  endproperty
  a_open_set: assert property (p_open_set) else $error("open event lost");

  property p_short_sticky;
    @(posedge CLK_I) disable iff (RST_I)
      (!short_clr && !soft_rst) |=> ((short_flag & $past(short_flag)) == $past(short_flag));
  endproperty
  a_short_sticky: assert property (p_short_sticky) else $error("short flag lost");

  property p_soft_pulse;
    @(posedge CLK_I) disable iff (RST_I)
      soft_rst |=> !soft_rst;
  endproperty
  a_soft_pulse: assert property (p_soft_pulse) else $error("soft reset too long");

  // Detections in the pulse cycle are dropped on purpose
  property p_soft_clears;
    @(posedge CLK_I) disable iff (RST_I)
      soft_rst |=> (open_flag == '0 && short_flag == '0);
  endproperty
  a_soft_clears: assert property (p_soft_clears) else $error("soft reset kept flags");

  property p_keep_short;
    @(posedge CLK_I) disable iff (RST_I)
      (open_clr && !short_clr && !soft_rst) |=>
        (short_flag == ($past(short_flag) | $past(evt.short_set)));
  endproperty
  a_keep_short: assert property (p_keep_short) else $error("short flags disturbed");

  property p_keep_open;
    @(posedge CLK_I) disable iff (RST_I)
      (short_clr && !open_clr && !soft_rst) |=>
        (open_flag == ($past(open_flag) | $past(evt.open_set)));
  endproperty
  a_keep_open: assert property (p_keep_open) else $error("open flags disturbed");

  property p_open_bad_cmd;
    @(posedge CLK_I) disable iff (RST_I)
      (wr_hit(req, lfr_pkg::OFS_OPEN_CLEAR) && !open_clr && !soft_rst) |=>
        (open_flag == ($past(open_flag) | $past(evt.open_set)));
  endproperty
  a_open_bad_cmd: assert property (p_open_bad_cmd) else $error("bad open code acted");

  property p_short_bad_cmd;
    @(posedge CLK_I) disable iff (RST_I)
      (wr_hit(req, lfr_pkg::OFS_SHORT_CLEAR) && !short_clr && !soft_rst) |=>
        (short_flag == ($past(short_flag) | $past(evt.short_set)));
  endproperty
  a_short_bad_cmd: assert property (p_short_bad_cmd) else $error("bad short code acted");

  property p_cmd_read;
    @(posedge CLK_I) disable iff (RST_I)
      (req.rd && (req.addr == lfr_pkg::OFS_OPEN_CLEAR || req.addr == lfr_pkg::OFS_SHORT_CLEAR))
        |=> (rvalid && rdata == lfr_pkg::READ_ZERO);
  endproperty
  a_cmd_read: assert property (p_cmd_read) else $error("clear reg read nonzero");

  property p_open_drop;
    @(posedge CLK_I) disable iff (RST_I)
      (open_clr && !soft_rst && !(|evt.open_set)) |=> !(|open_flag);
  endproperty
  a_open_drop: assert property (p_open_drop) else $error("open summary kept");

  property p_short_drop;
    @(posedge CLK_I) disable iff (RST_I)
      (short_clr && !soft_rst && !(|evt.short_set)) |=> !(|short_flag);
  endproperty
  a_short_drop: assert property (p_short_drop) else $error("short summary kept");

  c_open_clear: cover property (@(posedge CLK_I) disable iff (RST_I) |open_flag ##1 open_clr);
  c_short_clear: cover property (@(posedge CLK_I) disable iff (RST_I) |short_flag ##1 short_clr);
  c_soft_reset: cover property (@(posedge CLK_I) disable iff (RST_I) soft_cmd ##1 soft_rst);
  c_set_on_clear: cover property (@(posedge CLK_I) disable iff (RST_I) open_clr && |evt.open_set);
  c_bad_code: cover property (@(posedge CLK_I) disable iff (RST_I)
    wr_hit(req, lfr_pkg::OFS_OPEN_CLEAR) && !open_clr);

endmodule

/* verification/lfr_host_model.sv */
/*
  Host controller model for the fault register bank: one-cycle write
  and read strobes, inputs changed 1 ns after the rising edge.
  Assumes read data and valid answer exactly one cycle after the strobe.
*/
`timescale 1ns/1ns
module lfr_host_model (
  // Clock
  input  wire logic       clk_i,
  // Read answer
  input  wire logic [7:0] rdata_i,
  input  wire logic       rvalid_i,
  // Request
  output logic            wr_o,
  output logic            rd_o,
  output logic [9:0]      addr_o,
  output logic [7:0]      wdata_o
);
  initial begin
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = 10'h000;
    wdata_o = 8'h00;
  end

  task automatic reg_write(input logic [9:0] a, input logic [7:0] d);
    // Only the listed command offsets are ever written
    if (a inside {lfr_pkg::OFS_OPEN_CLEAR, lfr_pkg::OFS_SHORT_CLEAR,
                  lfr_pkg::OFS_SOFT_RESET}) begin
      @(posedge clk_i);
      #1;
      wr_o = 1'b1;
      addr_o = a;
      wdata_o = d;
      @(posedge clk_i);
      #1;
      wr_o = 1'b0;
      // Released bus shows garbage, not the last value
      addr_o = ~a;
      wdata_o = ~d;
    end
  endtask

  task automatic reg_read(input logic [9:0] a, output logic [8:0] ans);
    @(posedge clk_i);
    #1;
    rd_o = 1'b1;
    addr_o = a;
    @(posedge clk_i);
    #1;
    rd_o = 1'b0;
    addr_o = ~a;
    ans = {rvalid_i, rdata_i};
  endtask
endmodule

/* verification/testbench.sv */
/*
  Self-checking bench for the fault register bank: random fault events,
  clears, software and hardware reset, all offsets read back.
  Assumes lfr_host_model drives the register port.
*/
`timescale 1ns/1ns
module testbench;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        wr, rd, rvalid, soft_rst;
  logic [9:0]  addr, a;
  logic [7:0]  wdata, rdata, wd;
  logic [17:0] open_set = 18'h00000;
  logic [17:0] short_set = 18'h00000;
  logic [17:0] open_fl, short_fl, open_m, short_m;
  logic [31:0] r1, r2, r3;
  int          n_errors = 0;
  int          samples_checked = 0;
  int          seed = 22;

  always #50 clk = ~clk;

  lfr_fault_regs u_lfr_fault_regs (.CLK_I(clk), .RST_I(rst), .REG_WR_I(wr),
    .REG_RD_I(rd), .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata),
    .REG_RVALID_O(rvalid), .OPEN_SET_I(open_set), .SHORT_SET_I(short_set),
    .OPEN_FLAGS_O(open_fl), .SHORT_FLAGS_O(short_fl), .SOFT_RESET_O(soft_rst));
  lfr_host_model u_lfr_host_model (.clk_i(clk), .rdata_i(rdata), .rvalid_i(rvalid),
    .wr_o(wr), .rd_o(rd), .addr_o(addr), .wdata_o(wdata));

  function automatic logic [7:0] exp_reg(input logic [9:0] ad);
    case (ad)
      lfr_pkg::OFS_GLOBAL_FAULT: return {6'h00, |open_m, |short_m};
      lfr_pkg::OFS_OPEN_LOW:     return open_m[7:0];
      lfr_pkg::OFS_OPEN_MID:     return open_m[15:8];
      lfr_pkg::OFS_OPEN_TOP:     return {6'h00, open_m[17:16]};
      lfr_pkg::OFS_SHORT_LOW:    return short_m[7:0];
      lfr_pkg::OFS_SHORT_MID:    return short_m[15:8];
      lfr_pkg::OFS_SHORT_TOP:    return {6'h00, short_m[17:16]};
      default:                   return 8'h00;
    endcase
  endfunction

  task automatic check(input logic [17:0] got, input logic [17:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic read_all();
    logic [9:0] list [$] = '{10'h063, 10'h064, 10'h065, 10'h066, 10'h067, 10'h068,
      10'h085, 10'h086, 10'h087, 10'h088, 10'h089, 10'h0a7, 10'h0a8, 10'h0a9, 10'h100};
    logic [8:0] ans;
    foreach (list[i]) begin
      u_lfr_host_model.reg_read(list[i], ans);
      check({9'h0, ans}, {10'h1, exp_reg(list[i])});
    end
    check(open_fl, open_m);
    check(short_fl, short_m);
  endtask

  task automatic pulse(input logic [17:0] o, input logic [17:0] s);
    @(posedge clk);
    #1;
    open_set = o;
    short_set = s;
    @(posedge clk);
    #1;
    open_set = 18'h00000;
    short_set = 18'h00000;
    open_m |= o;
    short_m |= s;
  endtask

  // Events land in the same cycle as the write strobe
  task automatic wr_ev(input logic [9:0] ad, input logic [7:0] d,
                       input logic [17:0] o, input logic [17:0] s);
    fork
      u_lfr_host_model.reg_write(ad, d);
      pulse(o, s);
    join
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    #1_000_000;
    n_errors++;
    finish_test();
  end

  initial begin
    open_m = 18'h00000;
    short_m = 18'h00000;
    repeat (10) @(posedge clk);
    #1;
    rst = 1'b0;
    read_all();
    $display("test reset_values done");
    for (int i = 0; i < 12; i++) begin
      r1 = $random(seed);
      r2 = $random(seed);
      pulse(r1[17:0], (i == 11) ? 18'h3ffff : r2[17:0]);
      read_all();
      r1 = $random(seed) & $random(seed);
      r2 = $random(seed) & $random(seed);
      r3 = $random(seed);
      wd = r3[7:0];
      if (i % 3 != 2) begin
        wd[3:0] = 4'hf;
      end
      a = i[0] ? lfr_pkg::OFS_SHORT_CLEAR : lfr_pkg::OFS_OPEN_CLEAR;
      wr_ev(a, wd, r1[17:0], r2[17:0]);
      // Set wins over a clear in the same cycle
      if (wd[3:0] == 4'hf && !i[0]) open_m = r1[17:0];
      if (wd[3:0] == 4'hf && i[0]) short_m = r2[17:0];
      read_all();
    end
    $display("test random_set_clear done");
    wr_ev(lfr_pkg::OFS_SOFT_RESET, 8'hfe, 18'h00000, 18'h00000);
    check({17'h00000, soft_rst}, 18'h00000);
    r1 = $random(seed);
    // Events land in the cycle where the reset pulse stands and must be lost
    fork
      u_lfr_host_model.reg_write(lfr_pkg::OFS_SOFT_RESET, 8'hff);
      begin
        repeat (2) @(posedge clk);
        #1;
        open_set = r1[17:0];
        short_set = r1[31:14];
      end
    join
    check({17'h00000, soft_rst}, 18'h00001);
    @(posedge clk);
    #1;
    open_set = 18'h00000;
    short_set = 18'h00000;
    open_m = 18'h00000;
    short_m = 18'h00000;
    check({17'h00000, soft_rst}, 18'h00000);
    read_all();
    $display("test soft_reset done");
    pulse(18'h2a5a5, 18'h15a5a);
    #20;
    rst = 1'b1;
    #10;
    check(open_fl, 18'h00000);
    check(short_fl, 18'h00000);
    @(posedge clk);
    #1;
    rst = 1'b0;
    open_m = 18'h00000;
    short_m = 18'h00000;
    read_all();
    $display("test hard_reset done");
    finish_test();
  end
endmodule
